//--- pkg/cefr_regs.vh
// register offsets, field positions and reset values of the charger event flags
`ifndef CEFR_REGS_VH
`define CEFR_REGS_VH
`define CEFR_OFS_FLAGS_TWO   8'h24
`define CEFR_OFS_INT_STATUS  8'h28
`define CEFR_OFS_INT_MASK    8'h2c
`define CEFR_OFS_CONV_MODE   8'h30
`define CEFR_RST_FLAGS       8'h00
`define CEFR_RST_MASK        8'h00
`define CEFR_BIT_TOPOFF      0
`define CEFR_BIT_PRECHG      1
`define CEFR_BIT_TRICKLE     2
`define CEFR_BIT_FASTCHG     3
`define CEFR_BIT_MINSYS      4
`define CEFR_BIT_CONV        5
`define CEFR_BIT_DLDET       6
`define CEFR_BIT_RSVD        7
`define CEFR_FLAG_MASK       8'h7f
`endif

//--- sim/cefr_event_flags_checker.sv
// assertions on the flag register bus answers and flag reads
`timescale 1ns/1ps
module cefr_event_flags_checker (
  // clock, reset, bus and interrupt
  input wire        clk_sys, reset, avsRead, avsWaitRequest, irq,
  input wire [7:0]  avsAddress,
  input wire [31:0] avsReadData,
  // event sources
  input wire        topOffExpired, prechargeExpired, trickleExpired,
  input wire        fastChargeExpired, dataLineDetectDone
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // answer to a read of the flag register
  sequence ans;
    avsRead && avsAddress == 8'h24 && !avsWaitRequest;
  endsequence
  // an edge followed by a read answered seven cycles later is reported
  property p_set(logic s, int b);
    $rose(s) ##1 (!ans)[*6] ##1 ans |-> avsReadData[b];
  endproperty
  chk_wait_one: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low longer than one cycle");
  chk_rst_idle: assert property ($fell(reset) |-> avsWaitRequest && !irq)
    else $error("bus or irq not idle after reset");
  chk_rsvd_zero: assert property (ans |-> avsReadData[31:7] == 25'h0)
    else $error("reserved flag bits not zero");
  chk_topoff_set: assert property (p_set(topOffExpired, 0))
    else $error("top-off flag missing");
  chk_precharge_set: assert property (p_set(prechargeExpired, 1))
    else $error("precharge flag missing");
  chk_trickle_set: assert property (p_set(trickleExpired, 2))
    else $error("trickle flag missing");
  chk_fast_set: assert property (p_set(fastChargeExpired, 3))
    else $error("fast-charge flag missing");
  chk_detect_set: assert property (p_set(dataLineDetectDone, 6))
    else $error("detection done flag missing");
endmodule
bind cefr_event_flags cefr_event_flags_checker cefr_chk_i (.clk_sys, .reset,
  .avsRead, .avsWaitRequest, .irq, .avsAddress, .avsReadData, .topOffExpired,
  .prechargeExpired, .trickleExpired, .fastChargeExpired, .dataLineDetectDone);

//--- sim/testbench.sv
// self-checking bench for the charger event flag register
`timescale 1ns/1ps
module testbench;
  reg         clk_sys, reset, avsRead, avsWrite;
  reg  [7:0]  avsAddress;
  reg  [31:0] avsWriteData;
  reg  [6:0]  src;
  wire [31:0] avsReadData;
  wire        avsWaitRequest, irq;
  wire [1:0]  avsResponse;
  integer     mismatches, n_compared, i;
  cefr_event_flags cefr_event_flags_i (.clk_sys, .reset, .avsAddress,
    .avsRead, .avsWrite, .avsWriteData, .avsByteEnable(4'h1), .avsReadData,
    .avsWaitRequest, .avsResponse, .dataLineDetectDone(src[6]),
    .convDone(src[5]), .minSysRegActive(src[4]), .fastChargeExpired(src[3]),
    .trickleExpired(src[2]), .prechargeExpired(src[1]),
    .topOffExpired(src[0]), .irq);
  task chk(input [31:0] s, input [31:0] e, input string n);
    n_compared = n_compared + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // one bus access; read data and response taken where waitrequest is low
  task acc(input w, input [7:0] a, input [7:0] d, input [31:0] e,
           input [1:0] r);
    @(posedge clk_sys);
    avsAddress <= a;
    avsRead <= !w;
    avsWrite <= w;
    avsWriteData <= {24'h0, d};
    do @(posedge clk_sys); while (avsWaitRequest !== 1'b0);
    if (!w) chk(avsReadData, e, "readdata");
    chk(avsResponse, r, "response");
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  // one pulse on an event source, then let it settle
  task ev(input integer b);
    @(posedge clk_sys) src[b] <= 1'b1;
    @(posedge clk_sys) src[b] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // clock generator
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // watchdog
  initial begin
    #200000 mismatches = mismatches + 1;
    end_sim;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWriteData, src} = 49'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    acc(0, 8'h24, 8'h0, 32'h0, 2'h0);
    for (i = 0; i < 7; i = i + 1) begin
      if (i < 4 || i == 6) begin
        ev(i);
        acc(0, 8'h24, 8'h0, 32'h1 << i, 2'h0);
        acc(0, 8'h24, 8'h0, 32'h0, 2'h0);
      end
    end
    ev(5);
    acc(0, 8'h24, 8'h0, 32'h0, 2'h0);
    acc(1, 8'h30, 8'h1, 32'h0, 2'h0);
    ev(5);
    acc(0, 8'h24, 8'h0, 32'h20, 2'h0);
    ev(4);
    acc(0, 8'h24, 8'h0, 32'h10, 2'h0);
    acc(1, 8'h28, 8'hff, 32'h0, 2'h0);
    acc(1, 8'h2c, 8'h08, 32'h0, 2'h0);
    ev(2);
    chk(irq, 32'h0, "irq masked");
    ev(3);
    chk(irq, 32'h1, "irq");
    acc(1, 8'h28, 8'h08, 32'h0, 2'h0);
    repeat (3) @(posedge clk_sys);
    chk(irq, 32'h0, "irq cleared");
    acc(0, 8'h40, 8'h0, 32'h0, 2'h2);
    end_sim;
  end
endmodule

//--- verilog/cefr_event_flags.v
// charger event flag register two with avalon-mm slave and interrupt
`timescale 1ns/1ps
`include "cefr_regs.vh"
module cefr_event_flags (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // avalon-mm slave
  input  wire [7:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output reg  [31:0] avsReadData,
  output reg         avsWaitRequest,
  output reg  [1:0]  avsResponse,
  // event sources, levels from the charger functions
  input  wire        dataLineDetectDone,
  input  wire        convDone,
  input  wire        minSysRegActive,
  input  wire        fastChargeExpired,
  input  wire        trickleExpired,
  input  wire        prechargeExpired,
  input  wire        topOffExpired,
  // interrupt
  output reg         irq
);

  // bus timing in short:
  // a request is first seen at one edge, where the answer word is
  // captured and waitrequest drops; at the next edge the master sees
  // waitrequest low, takes the answer, and side effects happen there.
  // every access therefore costs exactly one wait cycle.
  // a request may follow straight after the take edge.
  // unmapped offsets answer zero with a slave error and write nothing.
  // only byte lane 0 carries register bits.

  // event handling in short:
  // timer expiries and completions are flagged on their rising edge;
  // the regulation flag is flagged on any change of its level;
  // the conversion flag only counts while one-shot mode is set;
  // flags stick until the flag register is read;
  // the interrupt status copies every event and is write-one-to-clear;
  // the interrupt line follows status bits that the mask lets through.

  // register storage
  reg  [7:0]  flags_q;
  reg  [7:0]  intStatus_q;
  reg  [7:0]  intMask_q;
  reg         oneShot_q;
  reg  [6:0]  srcPrev_q;
  reg         ack_q;

  // event detection
  wire [6:0]  srcNow;
  wire [7:0]  evt;

  // bus decode
  wire        req;
  wire        first;
  wire        take;
  wire        selFlags;
  wire        selStatus;
  wire        selMask;
  wire        selMode;
  wire        hit;
  wire        readFlags;
  wire        wrLane0;
  wire        wrStatus;
  wire        wrMask;
  wire        wrMode;

  // next values
  wire [7:0]  flags_d;
  wire [7:0]  flagsClr;
  wire [7:0]  intStatus_d;
  wire [7:0]  statusClr;
  wire [7:0]  intMask_d;
  wire        oneShot_d;
  wire        ack_d;
  wire        irq_d;
  wire [31:0] readWord;
  wire [1:0]  resp_d;

  // turn an event vector into its 8-bit register layout, bit 7 zero
  function [7:0] cefr_pack;
    input [6:0] v;
    begin
      cefr_pack = {1'b0, v} & `CEFR_FLAG_MASK;
    end
  endfunction

  // true when the bus address selects the given register offset
  function cefr_sel;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      cefr_sel = (addr == ofs);
    end
  endfunction

  // place an 8-bit register in the low byte of a bus word
  function [31:0] cefr_word;
    input [7:0] v;
    begin
      cefr_word = {24'h00_0000, v};
    end
  endfunction

  // rising edge of a level against its previous sample
  function cefr_rise;
    input now;
    input prev;
    begin
      cefr_rise = now & ~prev;
    end
  endfunction

  // gather the event sources in flag bit order
  assign srcNow = {dataLineDetectDone, convDone, minSysRegActive,
                   fastChargeExpired, trickleExpired, prechargeExpired,
                   topOffExpired};

  // timer expiries are flagged on their rising edge
  assign evt[`CEFR_BIT_TOPOFF]  = cefr_rise(topOffExpired,
                                            srcPrev_q[0]);
  assign evt[`CEFR_BIT_PRECHG]  = cefr_rise(prechargeExpired,
                                            srcPrev_q[1]);
  assign evt[`CEFR_BIT_TRICKLE] = cefr_rise(trickleExpired,
                                            srcPrev_q[2]);
  assign evt[`CEFR_BIT_FASTCHG] = cefr_rise(fastChargeExpired,
                                            srcPrev_q[3]);

  // regulation entry and exit both count
  assign evt[`CEFR_BIT_MINSYS]  = minSysRegActive ^ srcPrev_q[4];

  // conversion completion, only while one-shot mode is set
  assign evt[`CEFR_BIT_CONV]    = oneShot_q
                                  & cefr_rise(convDone, srcPrev_q[5]);
  // detection completion; nothing while detection is idle or running
  assign evt[`CEFR_BIT_DLDET]   = cefr_rise(dataLineDetectDone,
                                            srcPrev_q[6]);
  // reserved bit never sets
  assign evt[`CEFR_BIT_RSVD]    = 1'b0;

  // a request is first seen while no answer is pending
  assign req   = avsRead | avsWrite;
  assign first = req & ~ack_q;
  assign take  = req & ack_q;

  // register select, one wire per mapped offset
  assign selFlags  = cefr_sel(avsAddress, `CEFR_OFS_FLAGS_TWO);
  assign selStatus = cefr_sel(avsAddress, `CEFR_OFS_INT_STATUS);
  assign selMask   = cefr_sel(avsAddress, `CEFR_OFS_INT_MASK);
  assign selMode   = cefr_sel(avsAddress, `CEFR_OFS_CONV_MODE);
  assign hit       = selFlags | selStatus | selMask | selMode;

  // side effects happen only at the edge where the access is taken
  assign readFlags = take & avsRead & selFlags;
  assign wrLane0   = take & avsWrite & avsByteEnable[0];
  assign wrStatus  = wrLane0 & selStatus;
  assign wrMask    = wrLane0 & selMask;
  assign wrMode    = wrLane0 & selMode;

  // a read clears only the bits it reported: the answer word still
  // holds that snapshot at the take edge, so later events survive
  assign flagsClr = readFlags ? avsReadData[7:0] : 8'h00;

  // a new event wins over the clear
  assign flags_d  = ((flags_q & ~flagsClr) | evt)
                    & `CEFR_FLAG_MASK;

  // interrupt status: write one to clear, set wins
  assign statusClr   = wrStatus ? avsWriteData[7:0] : 8'h00;
  assign intStatus_d = (intStatus_q & ~statusClr) | cefr_pack(evt[6:0]);

  // mask and mode registers written by software
  assign intMask_d = wrMask ? (avsWriteData[7:0] & `CEFR_FLAG_MASK)
                            : intMask_q;
  // one-shot conversion mode enable
  assign oneShot_d = wrMode ? avsWriteData[0] : oneShot_q;

  // level interrupt from unmasked status bits
  assign irq_d = |(intStatus_d & intMask_q);

  // answer is pending for exactly one cycle after a first sighting
  assign ack_d = first;

  // read mux; reserved and upper bits read zero
  assign readWord = selFlags  ? cefr_word(flags_q) :
                    selStatus ? cefr_word(intStatus_q) :
                    selMask   ? cefr_word(intMask_q) :
                    selMode   ? {31'h0000_0000, oneShot_q} :
                    32'h0000_0000;

  // slave error when the offset is unmapped
  assign resp_d = hit ? 2'h0 : 2'h2;

  // flag storage, cleared on reset
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_q <= `CEFR_RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // interrupt status storage
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      intStatus_q <= `CEFR_RST_FLAGS;
    end else begin
      intStatus_q <= intStatus_d;
    end
  end

  // previous source levels for edge detection; a source already high
  // when reset ends is seen as an event, except convDone, since one-shot mode is off after reset
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      srcPrev_q <= 7'h00;
    end else begin
      srcPrev_q <= srcNow;
    end
  end

  // interrupt output register
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_d;
    end
  end

  // interrupt mask register
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      intMask_q <= `CEFR_RST_MASK;
    end else begin
      intMask_q <= intMask_d;
    end
  end

  // conversion mode register
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oneShot_q <= 1'b0;
    end else begin
      oneShot_q <= oneShot_d;
    end
  end

  // answer pending marker
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // waitrequest is high while idle and low for the answer cycle only
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avsWaitRequest <= 1'b1;
    end else begin
      avsWaitRequest <= ~first;
    end
  end

  // read data captured at first sighting, held until the next access
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avsReadData <= 32'h0000_0000;
    end else if (first) begin
      avsReadData <= readWord;
    end
  end

  // response code captured with the read data
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avsResponse <= 2'h0;
    end else if (first) begin
      avsResponse <= resp_d;
    end
  end

endmodule
